// ===== core/lcgs_data_mux.v
`include "lcgs_map.vh"
`default_nettype none

module lcgs_data_mux #(
	parameter [3:0] BASE = 4'h0
) (
	// cell sources, already synchronised
	input  wire [15:0] src,
	// selection code from the data select register
	input  wire [2:0]  code,
	// chosen data input
	output wire        data_out
);

	wire [3:0] idx;

	// window of eight sources starting at BASE, wrapping at sixteen
	assign idx      = BASE + {1'b0, code};
	assign data_out = src[idx];

endmodule

`default_nettype wire

// ===== core/lcgs_gate.v
`include "lcgs_map.vh"
`default_nettype none

module lcgs_gate (
	// the four selected data inputs, bit 0 is data input 1
	input  wire [3:0] data_in,
	// gate input select register
	input  wire [7:0] sel,
	// gate result before any polarity stage
	output wire       gate_out
);

	wire [7:0] versions;

	assign versions[`LCGS_BIT_D4_TRUE] = data_in[3];
	assign versions[`LCGS_BIT_D4_INV]  = ~data_in[3];
	assign versions[`LCGS_BIT_D3_TRUE] = data_in[2];
	assign versions[`LCGS_BIT_D3_INV]  = ~data_in[2];
	assign versions[`LCGS_BIT_D2_TRUE] = data_in[1];
	assign versions[`LCGS_BIT_D2_INV]  = ~data_in[1];
	assign versions[`LCGS_BIT_D1_TRUE] = data_in[0];
	assign versions[`LCGS_BIT_D1_INV]  = ~data_in[0];

	// cleared bits mask their version out; an empty mask gives zero
	assign gate_out = |(versions & sel);

endmodule

`default_nettype wire

// ===== core/lcgs_map.vh
`ifndef LCGS_MAP_VH
`define LCGS_MAP_VH

// register byte offsets, compared against haddr[7:0]
`define LCGS_OFS_GATE1       8'h00
`define LCGS_OFS_GATE2       8'h04
`define LCGS_OFS_GATE3       8'h08
`define LCGS_OFS_DSEL_LO     8'h0C
`define LCGS_OFS_DSEL_HI     8'h10
`define LCGS_OFS_STATUS      8'h14

// reset values
`define LCGS_RST_GATE        8'h00
`define LCGS_RST_DSEL        3'h0
`define LCGS_RST_ADDR        8'h00
`define LCGS_RST_WORD        32'h0000_0000

// data select field positions inside the two select registers
`define LCGS_DSEL_LO_FIELD   0
`define LCGS_DSEL_HI_FIELD   4
`define LCGS_DSEL_W          3

// source index offset of each data input's multiplexer window
`define LCGS_SRC_BASE_D1     4'h0
`define LCGS_SRC_BASE_D2     4'h4
`define LCGS_SRC_BASE_D3     4'h8
`define LCGS_SRC_BASE_D4     4'hC

// status register field positions
`define LCGS_STAT_DATA_LSB   0
`define LCGS_STAT_GATE_LSB   4

// gate select bit positions
`define LCGS_BIT_D4_TRUE     7
`define LCGS_BIT_D4_INV      6
`define LCGS_BIT_D3_TRUE     5
`define LCGS_BIT_D3_INV      4
`define LCGS_BIT_D2_TRUE     3
`define LCGS_BIT_D2_INV      2
`define LCGS_BIT_D1_TRUE     1
`define LCGS_BIT_D1_INV      0

// AHB-Lite encodings
`define LCGS_HTRANS_NONSEQ   2'h2
`define LCGS_HSIZE_BYTE      3'h0
`define LCGS_HSIZE_HALF      3'h1
`define LCGS_HSIZE_WORD      3'h2
`define LCGS_HRESP_OKAY      1'h0

`endif

// ===== core/lcgs_top.v
`include "lcgs_map.vh"
`default_nettype none

// Summary of operation
// - gate 1: bit 7 passes data 4 true, bit 6 passes data 4 inverted
// - gate 1: bit 5 passes data 3 true, bit 4 passes data 3 inverted
// - gate 1: bit 3 passes data 2 true, bit 2 passes data 2 inverted
// - gate 1: bit 1 passes data 1 true, bit 0 passes data 1 inverted
// - a cleared select bit keeps its data version out of the gate
// - gate 2: bit 7 data 4 true, bit 6 data 4 inverted
// - gate 2: bit 5 data 3 true, bit 4 data 3 inverted
// - gate 2: bit 3 data 2 true, bit 2 data 2 inverted
// - gate 2: bit 1 data 1 true, bit 0 data 1 inverted
// - gate 3: bit 7 data 4 true, bit 6 data 4 inverted
// - gate 3: bit 5 data 3 true, bit 4 data 3 inverted
// - gate 3: bit 3 data 2 true, bit 2 data 2 inverted
// - gate 3: bit 1 data 1 true, bit 0 data 1 inverted
// - select bits are software read/write; only power-on reset touches them
// - each data input picks one of eight sources in its window by a 3-bit code
module lcgs_top (
	// clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// AHB-Lite slave port
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire        hready,
	input  wire [31:0] hwdata,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	// cell source pins
	input  wire [15:0] cell_source_inputs,
	// gate results
	output wire        gate_one_out,
	output wire        gate_two_out,
	output wire        gate_three_out
);

	// source synchroniser, two stages per pin
	reg  [15:0] src_meta_q;
	reg  [15:0] src_sync_q;

	// address phase captured for the data phase
	reg         dp_valid_q;
	reg         dp_write_q;
	reg         dp_lane0_q;
	reg  [7:0]  dp_addr_q;

	// software registers
	reg  [7:0]  gate1_input_select_q;
	reg  [7:0]  gate2_input_select_q;
	reg  [7:0]  gate3_input_select_q;
	reg  [2:0]  d1_source_q;
	reg  [2:0]  d2_source_q;
	reg  [2:0]  d3_source_q;
	reg  [2:0]  sel_in_4_source_field_q;

	// address phase decode
	wire        ap_take;
	wire        ap_lane0;
	wire [7:0]  ap_addr;

	// data phase write strobes
	wire        wr_any;
	reg         wr_gate1;
	reg         wr_gate2;
	reg         wr_gate3;
	reg         wr_dsel_lo;
	reg         wr_dsel_hi;

	// datapath
	wire [3:0]  data_sel;
	wire [2:0]  gate_res;
	wire [7:0]  gate_sel [0:2];
	wire [2:0]  src_code [0:3];

	// address phase register hits
	reg         hit_gate1;
	reg         hit_gate2;
	reg         hit_gate3;
	reg         hit_dsel_lo;
	reg         hit_dsel_hi;
	reg         hit_status;

	// read path
	reg  [31:0] rd_word;
	reg  [7:0]  gate1_view;
	reg  [7:0]  gate2_view;
	reg  [7:0]  gate3_view;
	reg  [7:0]  dsel_lo_view;
	reg  [7:0]  dsel_hi_view;
	reg  [7:0]  status_view;
	wire [7:0]  wr_byte;

	// zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = `LCGS_HRESP_OKAY;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_meta_q <= 16'h0000;
			src_sync_q <= 16'h0000;
		end else begin
			src_meta_q <= cell_source_inputs;
			src_sync_q <= src_meta_q;
		end
	end

	assign ap_take = hsel & hready & htrans[1];
	assign ap_addr = haddr[7:0];

	// registers sit in byte lane 0; a write not covering it is dropped
	assign ap_lane0 = (hsize == `LCGS_HSIZE_WORD) ||
		((hsize == `LCGS_HSIZE_HALF) && (haddr[1] == 1'b0)) ||
		((hsize == `LCGS_HSIZE_BYTE) && (haddr[1:0] == 2'h0));

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid_q <= 1'b0;
			dp_write_q <= 1'b0;
			dp_lane0_q <= 1'b0;
			dp_addr_q  <= `LCGS_RST_ADDR;
		end else if (hready) begin
			dp_valid_q <= ap_take;
			dp_write_q <= hwrite;
			dp_lane0_q <= ap_lane0;
			dp_addr_q  <= ap_addr;
		end
	end

	assign wr_any  = dp_valid_q & dp_write_q & dp_lane0_q;
	assign wr_byte = hwdata[7:0];

	always @* begin
		wr_gate1   = 1'b0;
		wr_gate2   = 1'b0;
		wr_gate3   = 1'b0;
		wr_dsel_lo = 1'b0;
		wr_dsel_hi = 1'b0;
		if (!wr_any) begin
			wr_gate1 = 1'b0;
		end else if (dp_addr_q == `LCGS_OFS_GATE1) begin
			wr_gate1 = 1'b1;
		end else if (dp_addr_q == `LCGS_OFS_GATE2) begin
			wr_gate2 = 1'b1;
		end else if (dp_addr_q == `LCGS_OFS_GATE3) begin
			wr_gate3 = 1'b1;
		end else if (dp_addr_q == `LCGS_OFS_DSEL_LO) begin
			wr_dsel_lo = 1'b1;
		end else if (dp_addr_q == `LCGS_OFS_DSEL_HI) begin
			wr_dsel_hi = 1'b1;
		end
	end

	// hresetn stands for power-on; the undefined value is taken as zero
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gate1_input_select_q <= `LCGS_RST_GATE;
			gate2_input_select_q <= `LCGS_RST_GATE;
			gate3_input_select_q <= `LCGS_RST_GATE;
		end else begin
			if (wr_gate1) begin
				gate1_input_select_q <= wr_byte;
			end
			if (wr_gate2) begin
				gate2_input_select_q <= wr_byte;
			end
			if (wr_gate3) begin
				gate3_input_select_q <= wr_byte;
			end
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			d1_source_q             <= `LCGS_RST_DSEL;
			d2_source_q             <= `LCGS_RST_DSEL;
			d3_source_q             <= `LCGS_RST_DSEL;
			sel_in_4_source_field_q <= `LCGS_RST_DSEL;
		end else begin
			if (wr_dsel_lo) begin
				d1_source_q <= wr_byte[`LCGS_DSEL_LO_FIELD +: `LCGS_DSEL_W];
				d2_source_q <= wr_byte[`LCGS_DSEL_HI_FIELD +: `LCGS_DSEL_W];
			end
			if (wr_dsel_hi) begin
				d3_source_q <= wr_byte[`LCGS_DSEL_LO_FIELD +: `LCGS_DSEL_W];
				sel_in_4_source_field_q <=
					wr_byte[`LCGS_DSEL_HI_FIELD +: `LCGS_DSEL_W];
			end
		end
	end

	assign src_code[0] = d1_source_q;
	assign src_code[1] = d2_source_q;
	assign src_code[2] = d3_source_q;
	assign src_code[3] = sel_in_4_source_field_q;

	// one multiplexer per data input, each with its own source window
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_dmux
			localparam [3:0] MUX_BASE = (gi == 0) ? `LCGS_SRC_BASE_D1 :
				(gi == 1) ? `LCGS_SRC_BASE_D2 :
				(gi == 2) ? `LCGS_SRC_BASE_D3 : `LCGS_SRC_BASE_D4;
			lcgs_data_mux #(
				.BASE (MUX_BASE)
			) u_mux (
				.src      (src_sync_q),
				.code     (src_code[gi]),
				.data_out (data_sel[gi])
			);
		end
	endgenerate

	assign gate_sel[0] = gate1_input_select_q;
	assign gate_sel[1] = gate2_input_select_q;
	assign gate_sel[2] = gate3_input_select_q;

	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_gate
			lcgs_gate u_gate (
				.data_in  (data_sel),
				.sel      (gate_sel[gi]),
				.gate_out (gate_res[gi])
			);
		end
	endgenerate

	// kept combinational so a synchronised source edge reaches the gate outputs at once
	assign gate_one_out   = gate_res[0];
	assign gate_two_out   = gate_res[1];
	assign gate_three_out = gate_res[2];

	// a read right behind a write to the same word sees the new value
	always @* begin
		gate1_view = gate1_input_select_q;
		gate2_view = gate2_input_select_q;
		gate3_view = gate3_input_select_q;
		if (wr_gate1) begin
			gate1_view = wr_byte;
		end
		if (wr_gate2) begin
			gate2_view = wr_byte;
		end
		if (wr_gate3) begin
			gate3_view = wr_byte;
		end
	end

	// data select views; bits 7 and 3 are unused and read as zero
	always @* begin
		dsel_lo_view = 8'h00;
		dsel_hi_view = 8'h00;
		if (wr_dsel_lo) begin
			dsel_lo_view[`LCGS_DSEL_LO_FIELD +: `LCGS_DSEL_W] =
				wr_byte[`LCGS_DSEL_LO_FIELD +: `LCGS_DSEL_W];
			dsel_lo_view[`LCGS_DSEL_HI_FIELD +: `LCGS_DSEL_W] =
				wr_byte[`LCGS_DSEL_HI_FIELD +: `LCGS_DSEL_W];
		end else begin
			dsel_lo_view[`LCGS_DSEL_LO_FIELD +: `LCGS_DSEL_W] =
				d1_source_q;
			dsel_lo_view[`LCGS_DSEL_HI_FIELD +: `LCGS_DSEL_W] =
				d2_source_q;
		end
		if (wr_dsel_hi) begin
			dsel_hi_view[`LCGS_DSEL_LO_FIELD +: `LCGS_DSEL_W] =
				wr_byte[`LCGS_DSEL_LO_FIELD +: `LCGS_DSEL_W];
			dsel_hi_view[`LCGS_DSEL_HI_FIELD +: `LCGS_DSEL_W] =
				wr_byte[`LCGS_DSEL_HI_FIELD +: `LCGS_DSEL_W];
		end else begin
			dsel_hi_view[`LCGS_DSEL_LO_FIELD +: `LCGS_DSEL_W] =
				d3_source_q;
			dsel_hi_view[`LCGS_DSEL_HI_FIELD +: `LCGS_DSEL_W] =
				sel_in_4_source_field_q;
		end
	end

	// status is sampled at the address phase, one cycle old at most
	always @* begin
		status_view = 8'h00;
		status_view[`LCGS_STAT_DATA_LSB +: 4] = data_sel;
		status_view[`LCGS_STAT_GATE_LSB +: 3] = gate_res;
	end

	// decode the address phase once; unmapped offsets hit nothing
	always @* begin
		hit_gate1   = 1'b0;
		hit_gate2   = 1'b0;
		hit_gate3   = 1'b0;
		hit_dsel_lo = 1'b0;
		hit_dsel_hi = 1'b0;
		hit_status  = 1'b0;
		if (ap_addr == `LCGS_OFS_GATE1) begin
			hit_gate1 = 1'b1;
		end else if (ap_addr == `LCGS_OFS_GATE2) begin
			hit_gate2 = 1'b1;
		end else if (ap_addr == `LCGS_OFS_GATE3) begin
			hit_gate3 = 1'b1;
		end else if (ap_addr == `LCGS_OFS_DSEL_LO) begin
			hit_dsel_lo = 1'b1;
		end else if (ap_addr == `LCGS_OFS_DSEL_HI) begin
			hit_dsel_hi = 1'b1;
		end else if (ap_addr == `LCGS_OFS_STATUS) begin
			hit_status = 1'b1;
		end
	end

	// unmapped offsets and the unused upper lanes read as zero
	always @* begin
		rd_word = `LCGS_RST_WORD;
		if (hit_gate1) begin
			rd_word[7:0] = gate1_view;
		end else if (hit_gate2) begin
			rd_word[7:0] = gate2_view;
		end else if (hit_gate3) begin
			rd_word[7:0] = gate3_view;
		end else if (hit_dsel_lo) begin
			rd_word[7:0] = dsel_lo_view;
		end else if (hit_dsel_hi) begin
			rd_word[7:0] = dsel_hi_view;
		end else if (hit_status) begin
			rd_word[7:0] = status_view;
		end
	end

	// launched at the address phase edge, so it stands all data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= `LCGS_RST_WORD;
		end else if (ap_take && !hwrite) begin
			hrdata <= rd_word;
		end
	end

endmodule

`default_nettype wire

// ===== test/lcgs_properties.sv
`default_nettype none
module lcgs_props (
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// cell side
	input wire logic [15:0] cell_source_inputs,
	input wire logic        gate_one_out,
	input wire logic        gate_two_out,
	input wire logic        gate_three_out
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic [2:0] g;
	wire logic       take;
	assign g = {gate_three_out, gate_two_out, gate_one_out};
	assign take = hsel && hready && htrans[1];
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_wr_then_rd;
		take && hwrite && hsize == 3'h2
			&& haddr[7:0] inside {8'h00, 8'h04, 8'h08}
		##2 take && !hwrite && haddr == $past(haddr, 2);
	endsequence
	// three idle edges let the two-stage synchroniser settle
	sequence s_quiet;
		(!take && $stable(cell_source_inputs)) [*3];
	endsequence
	AST_OKAY: assert property (hresp == 1'b0)
		else $error("slave response not okay");
	AST_READY: assert property (hreadyout)
		else $error("wait state inserted");
	AST_TOP: assert property (hrdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	AST_RST_GATES: assert property ($rose(hresetn) |-> g == 3'h0)
		else $error("gate high after reset");
	AST_RST_DATA: assert property ($rose(hresetn) |-> hrdata == 32'h0)
		else $error("read data not clear after reset");
	AST_QUIET: assert property (s_quiet |-> $stable(g))
		else $error("gate moved with no cause");
	AST_WR_RD: assert property (s_wr_then_rd |=>
		hrdata[7:0] == $past(hwdata[7:0], 2))
		else $error("read back differs from write");
	AST_UNMAP: assert property (take && !hwrite
		&& haddr[7:0] >= 8'h18 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
endmodule
bind lcgs_top lcgs_props i_props (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
	.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .cell_source_inputs(cell_source_inputs),
	.gate_one_out(gate_one_out), .gate_two_out(gate_two_out),
	.gate_three_out(gate_three_out)
);
`default_nettype wire

// ===== test/lcgs_src_model.sv
`default_nettype none
// cell source pins follow the bench's request one edge later
module lcgs_src_model (
	// clock
	input  wire logic        hclk,
	// wanted source levels
	input  wire logic [15:0] want,
	// cell source pins
	output var  logic [15:0] pins
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pins = 16'h0000;
	always @(posedge hclk) begin
		pins <= want;
	end
endmodule
`default_nettype wire

// ===== test/logic_cell_gate_input_select_test.sv
`default_nettype none
module logic_cell_gate_input_select_test;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [7:0]  sel;
		logic [15:0] src;
		logic        hit;
	} lcgs_row_t;
	// zero codes route pins 0, 4, 8 and 12 to data 1 to 4
	lcgs_row_t rows [16] = '{
		'{8'h80, 16'h1000, 1'b1}, '{8'h80, 16'h0000, 1'b0},
		'{8'h40, 16'h0000, 1'b1}, '{8'h40, 16'h1000, 1'b0},
		'{8'h20, 16'h0100, 1'b1}, '{8'h10, 16'h0100, 1'b0},
		'{8'h10, 16'h0000, 1'b1}, '{8'h08, 16'h0010, 1'b1},
		'{8'h04, 16'h0010, 1'b0}, '{8'h04, 16'h0000, 1'b1},
		'{8'h02, 16'h0001, 1'b1}, '{8'h01, 16'h0001, 1'b0},
		'{8'h01, 16'h0000, 1'b1}, '{8'h00, 16'hFFFF, 1'b0},
		'{8'h55, 16'h1111, 1'b0}, '{8'hAA, 16'h0100, 1'b1}
	};
	logic [15:0] pat [3] = '{16'h8000, 16'h0008, 16'h1100};
	logic [31:0] stat [3] = '{32'h14, 32'h18, 32'h00};
	logic [15:0] lo_pat [3] = '{16'h0020, 16'h0800, 16'h0001};
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [15:0] want = 16'h0;
	logic [31:0] rd;
	wire  [31:0] hrdata;
	wire  [15:0] pins;
	wire         hreadyout;
	wire  [2:0]  g;
	int          err_total = 0;
	int          n_checks = 0;
	always #20 hclk = ~hclk;
	lcgs_top i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .cell_source_inputs(pins),
		.gate_one_out(g[0]), .gate_two_out(g[1]), .gate_three_out(g[2])
	);
	lcgs_src_model i_src (.hclk(hclk), .want(want), .pins(pins));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	// entered just after a rising edge; rd keeps the read data
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d, input logic [2:0] sz);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= sz;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// gates are sampled mid-cycle, clear of the launching edge
	task automatic gate_check(input logic [31:0] e);
		repeat (3) @(posedge hclk);
		@(negedge hclk);
		check(32'(g), e);
		@(posedge hclk);
	endtask
	task automatic stop_test;
		$display("checks %0d, errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#400000;
		err_total++;
		stop_test();
	end
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 6; i++) begin
			xfer(8'(4 * i), 1'b0, 32'h0, 3'h2);
			check(rd, 32'h0);
		end
		foreach (rows[r]) begin
			for (int k = 0; k < 3; k++) begin
				want <= rows[r].src;
				for (int j = 0; j < 3; j++)
					xfer(8'(4 * j), 1'b1, j == k ? 32'(rows[r].sel) : 32'h0, 3'h2);
				gate_check(rows[r].hit ? 32'h1 << k : 32'h0);
				xfer(8'(4 * k), 1'b0, 32'h0, 3'h2);
				check(rd, 32'(rows[r].sel));
			end
		end
		xfer(8'h10, 1'b1, 32'hFF, 3'h2);
		xfer(8'h10, 1'b0, 32'h0, 3'h2);
		check(rd, 32'h77);
		xfer(8'h00, 1'b1, 32'hA0, 3'h2);
		xfer(8'h08, 1'b1, 32'h00, 3'h2);
		for (int i = 0; i < 3; i++) begin
			want <= pat[i];
			gate_check(i < 2 ? 32'h1 : 32'h0);
			xfer(8'h14, 1'b0, 32'h0, 3'h2);
			check(rd, stat[i]);
		end
		// misaligned byte write must be dropped
		xfer(8'h01, 1'b1, 32'hFFFF_FFFF, 3'h0);
		xfer(8'h00, 1'b0, 32'h0, 3'h2);
		check(rd, 32'hA0);
		xfer(8'h40, 1'b1, 32'hFF, 3'h2);
		xfer(8'h40, 1'b0, 32'h0, 3'h2);
		check(rd, 32'h0);
		xfer(8'h04, 1'b1, 32'h5A, 3'h2);
		xfer(8'h04, 1'b0, 32'h0, 3'h2);
		check(rd, 32'h5A);
		// data 1 and 2 windows: code 5 picks pin 5, code 7 pin 11
		xfer(8'h04, 1'b1, 32'h0, 3'h2);
		xfer(8'h0C, 1'b1, 32'h75, 3'h2);
		xfer(8'h0C, 1'b0, 32'h0, 3'h2);
		check(rd, 32'h75);
		xfer(8'h00, 1'b1, 32'h0A, 3'h2);
		for (int i = 0; i < 3; i++) begin
			want <= lo_pat[i];
			gate_check(i < 2 ? 32'h1 : 32'h0);
		end
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		gate_check(32'h0);
		for (int i = 0; i < 5; i++) begin
			xfer(8'(4 * i), 1'b0, 32'h0, 3'h2);
			check(rd, 32'h0);
		end
		stop_test();
	end
endmodule
`default_nettype wire
